//--- src/wut_status_capture.sv
// wake-up timer status, flag clearing and event capture with ahb-lite slave
//
// Behaviour
// - any change of the timer enable sets the enable-sync flag
// - enable-sync flag clears once the enable reaches the slow tick domain
// - freeze flag shows high counter half frozen, drops when released
// - freezing happens only while the freeze-enable control bit is set
// - wake status bit mirrors the wake request to power-down control
// - active-high wake outputs assert on wake-up events
// - rising edge on selected capture line sets flag and latches count
// - reading the high capture register clears the capture flag
// - rollover flag set only in free-running mode at all ones or zeros
// - match flags set on comparator match only when enabled
// - rollover and match flags clear only by clear-register writes
// - clear bits: 3 rollover, 2 match c, 1 match b, 0 match a
// - written clear bits self-clear after crossing into the tick domain
// - clear bit 4 clears the capture event flag
// - captured count held as low half and high half registers
// - capture need only work in the active power state
// - disabled compare field does no comparison, its flag never sets
// - timer held in reset while enable is 0, runs when 1
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "wut_status_map.svh"

module wut_status_capture
  import wut_status_pkg::*;
#(
  parameter int CLK_HZ = `WUT_CLK_HZ,
  parameter int TICK_HZ = `WUT_TICK_HZ,
  parameter int COUNT_W = 32,
  parameter int EVENT_LINES = 8,
  parameter int SEL_W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_enable,
  input wire logic freeze_enable,
  input wire logic value_low_read,
  input wire logic value_high_read,
  input wire logic free_running,
  input wire logic count_down,
  input wire logic [COUNT_W-1:0] counter_value,
  input wire logic [2:0] match_hit,
  input wire logic [2:0] match_irq_enable,
  input wire logic [EVENT_LINES-1:0] event_lines,
  input wire logic [SEL_W-1:0] event_select,
  input wire logic system_active,
  output logic timer_run,
  output logic value_frozen,
  output logic [4:0] wake_lines
);

  // ----------------------------------------------------------------
  // slow tick divider
  // ----------------------------------------------------------------
  // the two rate parameters let a bench shorten the tick period
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

  logic [15:0] div_r;
  logic tick_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == TICK_LAST) begin
      div_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  ahb_req_type req;
  logic take;
  logic rd_take;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;

  // hsize is carried but ignored: only whole-word transfers are used
  assign req = '{
    haddr: haddr,
    htrans: htrans,
    hwrite: hwrite,
    hsize: hsize,
    hsel: hsel,
    hready: hready
  };
  assign take = req.hsel & req.hready & req.htrans[1];
  assign rd_take = take & ~req.hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
    end else begin
      wr_pend_r <= take & req.hwrite;
      if (take) begin
        wr_addr_r <= req.haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable synchronisation
  // ----------------------------------------------------------------
  logic en_seen_r;
  logic en_sync_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_seen_r <= 1'b0;
    end else begin
      en_seen_r <= timer_enable;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_run <= 1'b0;
    end else if (tick_r) begin
      timer_run <= timer_enable;
    end
  end

  // set has priority, so a toggle on a tick edge is not lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_sync_r <= 1'b0;
    end else if (en_seen_r != timer_enable) begin
      en_sync_r <= 1'b1;
    end else if (tick_r && timer_run == timer_enable) begin
      en_sync_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // counter value freeze
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_frozen <= 1'b0;
    end else if (!freeze_enable) begin
      value_frozen <= 1'b0;
    end else if (value_low_read) begin
      value_frozen <= 1'b1;
    end else if (value_high_read) begin
      value_frozen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clear register and its crossing into the tick domain
  // ----------------------------------------------------------------
  logic [`WUT_CLR_WIDTH-1:0] clr_r;
  logic [`WUT_CLR_WIDTH-1:0] clr_apply;
  logic clr_write;
  clr_state_type clr_state_r;

  // pending bits wait for the next tick, then clear their flags
  assign clr_write = wr_pend_r && wr_addr_r == `WUT_IRQ_CLEAR_ADDR;
  assign clr_apply = (tick_r && clr_state_r == CLR_WAIT) ? clr_r :
                     '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_r <= '0;
      clr_state_r <= CLR_IDLE;
    end else begin
      case (clr_state_r)
        CLR_IDLE: begin
          if (clr_write && hwdata[`WUT_CLR_WIDTH-1:0] != '0) begin
            clr_r <= hwdata[`WUT_CLR_WIDTH-1:0];
            clr_state_r <= CLR_WAIT;
          end
        end
        CLR_WAIT: begin
          if (clr_write && tick_r) begin
            // old bits apply on this tick; only the new ones stay pending
            clr_r <= hwdata[`WUT_CLR_WIDTH-1:0];
            if (hwdata[`WUT_CLR_WIDTH-1:0] == '0) begin
              clr_state_r <= CLR_IDLE;
            end
          end else if (clr_write) begin
            clr_r <= clr_r | hwdata[`WUT_CLR_WIDTH-1:0];
          end else if (tick_r) begin
            clr_r <= '0;
            clr_state_r <= CLR_IDLE;
          end
        end
        default: begin
          clr_r <= '0;
          clr_state_r <= CLR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rollover and match flags
  // ----------------------------------------------------------------
  logic roll_r;
  logic [2:0] match_r;
  logic roll_set;
  logic [2:0] match_set;

  assign roll_set = tick_r & timer_run & free_running &
                    (count_down ? (counter_value == '0) :
                     (counter_value == '1));
  assign match_set = {3{tick_r & timer_run}} & match_hit &
                     match_irq_enable;

  // a set on the clearing tick wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roll_r <= 1'b0;
    end else if (roll_set) begin
      roll_r <= 1'b1;
    end else if (clr_apply[`WUT_BIT_ROLL]) begin
      roll_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_r <= 3'h0;
    end else begin
      match_r <= (match_r & ~clr_apply[`WUT_BIT_MATCH_C:0]) |
                 match_set;
    end
  end

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  logic ev_prev_r;
  logic ev_now;
  logic cap_set;
  logic cap_r;
  logic cap_high_rd;
  logic [15:0] cap_low_r;
  logic [15:0] cap_high_r;

  // edge detector resets low, the idle level of the event lines
  assign ev_now = event_lines[event_select];
  assign cap_set = ev_now & ~ev_prev_r & system_active;
  assign cap_high_rd = rd_take && req.haddr == `WUT_CAP_HIGH_ADDR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_prev_r <= 1'b0;
    end else begin
      ev_prev_r <= ev_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_low_r <= `WUT_REG_RESET;
      cap_high_r <= `WUT_REG_RESET;
    end else if (cap_set) begin
      cap_low_r <= counter_value[15:0];
      cap_high_r <= counter_value[31:16];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_r <= 1'b0;
    end else if (cap_set) begin
      cap_r <= 1'b1;
    end else if (cap_high_rd || clr_apply[`WUT_BIT_CAPTURE]) begin
      cap_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake request to power-down control
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_lines <= 5'h00;
    end else begin
      wake_lines <= {cap_r, roll_r, match_r};
    end
  end

  // ----------------------------------------------------------------
  // status word and read data
  // ----------------------------------------------------------------
  status_type status;
  logic [31:0] status_word;

  assign status = '{
    en_sync: en_sync_r,
    freeze: value_frozen,
    wake: |wake_lines,
    capture: cap_r,
    roll: roll_r,
    match_c: match_r[2],
    match_b: match_r[1],
    match_a: match_r[0]
  };

  // each flag at its bit position, reserved bits read 0
  always_comb begin
    status_word = 32'h00000000;
    status_word[`WUT_BIT_EN_SYNC] = status.en_sync;
    status_word[`WUT_BIT_FREEZE] = status.freeze;
    status_word[`WUT_BIT_WAKE] = status.wake;
    status_word[`WUT_BIT_CAPTURE] = status.capture;
    status_word[`WUT_BIT_ROLL] = status.roll;
    status_word[`WUT_BIT_MATCH_C] = status.match_c;
    status_word[`WUT_BIT_MATCH_B] = status.match_b;
    status_word[`WUT_BIT_MATCH_A] = status.match_a;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      if (req.haddr == `WUT_IRQ_STATUS_ADDR) begin
        hrdata <= status_word;
      end else if (req.haddr == `WUT_IRQ_CLEAR_ADDR) begin
        hrdata <= {27'h0000000, clr_r};
      end else if (req.haddr == `WUT_CAP_LOW_ADDR) begin
        hrdata <= {16'h0000, cap_low_r};
      end else if (req.haddr == `WUT_CAP_HIGH_ADDR) begin
        hrdata <= {16'h0000, cap_high_r};
      end else begin
        hrdata <= 32'h00000000;
      end
    end else begin
      hrdata <= 32'h00000000;
    end
  end

endmodule : wut_status_capture
`default_nettype wire

//--- common/wut_status_map.svh
// register offsets, field positions, reset values and timing for the block
`ifndef WUT_STATUS_MAP_SVH
`define WUT_STATUS_MAP_SVH

`define WUT_IRQ_STATUS_ADDR 32'h4000252C
`define WUT_IRQ_CLEAR_ADDR 32'h40002530
`define WUT_CAP_LOW_ADDR 32'h4000253C
`define WUT_CAP_HIGH_ADDR 32'h40002540

`define WUT_REG_RESET 16'h0000

`define WUT_BIT_MATCH_A 0
`define WUT_BIT_MATCH_B 1
`define WUT_BIT_MATCH_C 2
`define WUT_BIT_ROLL 3
`define WUT_BIT_CAPTURE 4
`define WUT_BIT_WAKE 6
`define WUT_BIT_FREEZE 7
`define WUT_BIT_EN_SYNC 8

`define WUT_CLR_WIDTH 5

`define WUT_CLK_HZ 100000000
`define WUT_TICK_HZ 32768

`endif

//--- common/wut_status_pkg.sv
// types shared by the wake-up timer status and capture block
package wut_status_pkg;

  typedef struct packed {
    logic en_sync;
    logic freeze;
    logic wake;
    logic capture;
    logic roll;
    logic match_c;
    logic match_b;
    logic match_a;
  } status_type;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } ahb_req_type;

  typedef enum logic [1:0] {
    CLR_IDLE,
    CLR_WAIT
  } clr_state_type;

endpackage : wut_status_pkg

//--- tb/wut_status_capture_asserts.sv
// port-level checks for the wake-up timer status block
`timescale 1ns/10ps
`default_nettype none
`include "wut_status_map.svh"

module wut_status_capture_asserts
  import wut_status_pkg::*;
#(
  parameter int EVENT_LINES = 8,
  parameter int SEL_W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic timer_enable,
  input wire logic freeze_enable,
  input wire logic value_low_read,
  input wire logic value_high_read,
  input wire logic [2:0] match_irq_enable,
  input wire logic [EVENT_LINES-1:0] event_lines,
  input wire logic [SEL_W-1:0] event_select,
  input wire logic system_active,
  input wire logic timer_run,
  input wire logic value_frozen,
  input wire logic [4:0] wake_lines
);
  logic [7:0] clr_age;
  logic req;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign req = hsel && hready && htrans[1];

  // cycles since the last clear-register write, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_age <= 8'hFF;
    end else if (req && hwrite && haddr == `WUT_IRQ_CLEAR_ADDR) begin
      clr_age <= 8'h00;
    end else if (clr_age != 8'hFF) begin
      clr_age <= clr_age + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_run_on;
    timer_enable [*8] ##1 timer_enable [*2] |=> timer_run;
  endproperty
  a_run_on: assert property (p_run_on) else $error("timer not running");
  property p_run_off;
    !timer_enable [*8] ##1 !timer_enable [*2] |=> !timer_run;
  endproperty
  a_run_off: assert property (p_run_off) else $error("timer not held");
  property p_frz_off;
    !freeze_enable |=> !value_frozen;
  endproperty
  a_frz_off: assert property (p_frz_off) else $error("frozen unasked");
  property p_frz_set;
    freeze_enable && value_low_read && !value_high_read |=> value_frozen;
  endproperty
  a_frz_set: assert property (p_frz_set) else $error("freeze missing");
  property p_cap_set;
    system_active && $stable(event_select) &&
      $rose(event_lines[event_select]) |-> ##[1:4] wake_lines[4];
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("capture missed");
  property p_cap_clr;
    req && !hwrite && haddr == `WUT_CAP_HIGH_ADDR |-> ##[1:3] !wake_lines[4];
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture kept");
  property p_match_en;
    (wake_lines[2:0] & ~$past(wake_lines[2:0]) &
      ~$past(match_irq_enable, 2)) == 3'h0;
  endproperty
  a_match_en: assert property (p_match_en) else $error("match unenabled");
  property p_no_self_clr;
    |($past(wake_lines[3:0]) & ~wake_lines[3:0]) |-> clr_age < 8'h14;
  endproperty
  a_no_self_clr: assert property (p_no_self_clr) else $error("flag lost");
endmodule : wut_status_capture_asserts

bind wut_status_capture wut_status_capture_asserts #(
  .EVENT_LINES(EVENT_LINES), .SEL_W(SEL_W)
) wut_status_capture_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .timer_enable(timer_enable), .freeze_enable(freeze_enable),
  .value_low_read(value_low_read), .value_high_read(value_high_read),
  .match_irq_enable(match_irq_enable), .event_lines(event_lines),
  .event_select(event_select), .system_active(system_active),
  .timer_run(timer_run), .value_frozen(value_frozen),
  .wake_lines(wake_lines)
);
`default_nettype wire

//--- tb/wut_status_capture_tb_top.sv
// self-checking bench for the wake-up timer status block
`timescale 1ns/10ps
`default_nettype none
`include "wut_status_map.svh"

module wut_status_capture_tb_top import wut_status_pkg::*;;
  localparam logic [31:0] st_a = `WUT_IRQ_STATUS_ADDR;
  localparam logic [31:0] cl_a = `WUT_IRQ_CLEAR_ADDR;
  localparam logic [31:0] lo_a = `WUT_CAP_LOW_ADDR;
  localparam logic [31:0] hi_a = `WUT_CAP_HIGH_ADDR;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dph;
  logic [1:0] htrans;
  logic [2:0] hsize, match_hit, match_irq_enable, event_select;
  logic [31:0] haddr, hwdata, hrdata, counter_value, r, m;
  logic timer_enable, freeze_enable, value_low_read, value_high_read;
  logic free_running, count_down, system_active, timer_run, value_frozen;
  logic [4:0] wake_lines, f;
  logic [7:0] event_lines;
  logic [31:0] seed = 32'hD591;
  logic [31:0] ad[5] = '{st_a, cl_a, lo_a, hi_a, 32'h40002544};
  logic [31:0] exp_q[$];
  int bad_count, cmp_count;

  assign hready = hreadyout;

  wut_status_capture #(.CLK_HZ(800), .TICK_HZ(100)) wut_status_capture_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_enable(timer_enable), .freeze_enable(freeze_enable),
    .value_low_read(value_low_read), .value_high_read(value_high_read),
    .free_running(free_running), .count_down(count_down),
    .counter_value(counter_value), .match_hit(match_hit),
    .match_irq_enable(match_irq_enable), .event_lines(event_lines),
    .event_select(event_select), .system_active(system_active),
    .timer_run(timer_run), .value_frozen(value_frozen),
    .wake_lines(wake_lines)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // status word: wake bit is the or of all pending flags
  function automatic logic [31:0] sv(input logic [4:0] v);
    return {25'h0, |v, 1'b0, v};
  endfunction : sv

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic hw();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask : hw

  // one ahb-lite single transfer; for reads d is the expected word
  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hw();
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (w) hwdata <= d;
    else exp_q.push_back(d);
    dph <= !w;
    hw();
    dph <= 1'b0;
  endtask : xf

  task automatic en(input logic v);
    timer_enable <= v;
    idle(2);
    xf(1'b0, st_a, 32'h100);
    idle(30);
    xf(1'b0, st_a, 32'h0);
    chk({31'h0, timer_run}, {31'h0, v});
  endtask : en

  always @(posedge hclk) begin
    if (dph && hready === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
  end

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsize = 3'h2;
    system_active = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, dph, timer_enable, freeze_enable,
      value_low_read, value_high_read, free_running, count_down,
      counter_value, match_hit, match_irq_enable, event_lines,
      event_select} = '0;
    idle(10);
    hresetn <= 1'b1;
    idle(2);
    foreach (ad[i]) xf(1'b0, ad[i], 32'h0);
    xf(1'b1, lo_a, 32'hFFFF);
    xf(1'b0, lo_a, 32'h0);
    en(1'b1);
    repeat (4) begin
      r = xs();
      f = {1'b0, r[3:0]};
      match_irq_enable <= r[2:0];
      free_running <= r[3];
      count_down <= r[4];
      counter_value <= r[4] ? 32'h0 : 32'hFFFFFFFF;
      match_hit <= 3'h7;
      idle(20);
      match_hit <= 3'h0;
      free_running <= 1'b0;
      idle(30);
      xf(1'b0, st_a, sv(f));
      chk({27'h0, wake_lines}, {27'h0, f});
      m = xs();
      xf(1'b1, cl_a, {28'h0, m[3:0]});
      idle(30);
      xf(1'b0, st_a, sv(f & ~{1'b0, m[3:0]}));
      xf(1'b0, cl_a, 32'h0);
      xf(1'b1, cl_a, 32'hF);
      idle(30);
    end
    for (int k = 0; k < 2; k++) begin
      r = xs();
      counter_value <= r;
      event_select <= r[2:0];
      idle(2);
      event_lines <= 8'h01 << r[2:0];
      idle(3);
      counter_value <= ~r;
      xf(1'b0, st_a, sv(5'h10));
      xf(1'b0, lo_a, {16'h0, r[15:0]});
      if (k == 0) xf(1'b0, hi_a, {16'h0, r[31:16]});
      else xf(1'b1, cl_a, 32'h10);
      event_lines <= 8'h00;
      idle(30);
      xf(1'b0, st_a, 32'h0);
    end
    for (int k = 1; k >= 0; k--) begin
      freeze_enable <= k[0];
      value_low_read <= 1'b1;
      idle(1);
      value_low_read <= 1'b0;
      idle(2);
      xf(1'b0, st_a, k[0] ? 32'h80 : 32'h0);
      chk({31'h0, value_frozen}, {31'h0, k[0]});
      value_high_read <= 1'b1;
      idle(1);
      value_high_read <= 1'b0;
      idle(2);
      xf(1'b0, st_a, 32'h0);
    end
    en(1'b0);
    idle(5);
    summarize();
  end
endmodule : wut_status_capture_tb_top
`default_nettype wire
